/* hw/mocr_clock_reset.sv */
// Option clock, reset, supervisor, watchdog halt, voltage detect and two timers.
// Assumes all inputs synchronous to sys_clk and the register port of mocr_pkg.
// Operation
// - Source: 16/8/4/2 MHz or external clock.
// - CPU clock from doubler or halving, slow divide.
// - CPU clock kept within 250 kHz..8 MHz.
// - Two 16-bit timers, prescaler, compare, PWM, capture.
// - Freeze option stops counters at breakpoint.
// - Run option keeps counters counting at breakpoint.
// - Timer external clock never frozen by break.
// - Supervisor switches to backup on bad frequency.
// - Range codes: 16..8, 8..4, 4..2, 2..1 MHz.
// - Doubler multiplies by two, guaranteed 2..4 MHz.
// - Reset and halt exit hold 4096/256 cycles.
// - Halt with watchdog on resets chip.
// - No-reset option: halt causes no reset.
// - Watchdog enabled by software or hardware.
// - Voltage detect option gates detectors, large packages.
// - Low voltage detector off in halt.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "mocr_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module mocr_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cpuTick,
  input wire logic run,
  input wire logic extEdge,
  input wire logic useExt,
  input wire logic [3:0] presc,
  input wire logic [15:0] compare,
  input wire logic captureIn,
  output logic [15:0] counter,
  output logic [15:0] captured,
  output logic compareHit,
  output logic captureHit,
  output logic pwmOut
);
  logic [15:0] prescCnt;
  logic captureLast;
  logic step;
  logic prescIn;

  // The external edge bypasses the break gate on purpose.
  assign prescIn = useExt ? extEdge : (cpuTick & run);
  assign step = prescIn && (prescCnt == ((16'h0001 << presc) - 16'h0001));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prescCnt <= 16'h0000;
    end else if (step) begin
      prescCnt <= 16'h0000;
    end else if (prescIn) begin
      prescCnt <= prescCnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter <= 16'h0000;
      compareHit <= 1'b0;
    end else begin
      compareHit <= step && (counter == compare);
      if (step) begin
        counter <= counter + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= (counter < compare);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      captureLast <= 1'b0;
      captured <= 16'h0000;
      captureHit <= 1'b0;
    end else begin
      captureLast <= captureIn;
      captureHit <= captureIn & ~captureLast;
      if (captureIn & ~captureLast) begin
        captured <= counter;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mocr_clock_reset #(
  parameter int MEAS_CYCLES = `MOCR_MEAS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire mocr_pkg::mocr_opt_t optionIn,
  input wire mocr_pkg::mocr_bus_t bus,
  output logic [15:0] rdData,
  input wire logic externalClockInput,
  input wire logic [1:0] timerExternalClock,
  input wire logic [1:0] captureIn,
  input wire logic breakHalt,
  input wire logic haltInstr,
  input wire logic wakeUp,
  output logic [15:0] cpuFrequency,
  output logic cpuTick,
  output logic cpuReset,
  output logic haltMode,
  output logic backupActive,
  output logic watchdogActive,
  output logic externalVoltageDetect,
  output logic lowVoltageDetector,
  output logic auxiliaryVoltageDetector,
  output logic [1:0] pwmOut,
  output logic irq
);
  localparam int MEAS_SCALE = 10000 / MEAS_CYCLES;

  mocr_pkg::mocr_opt_t opt;
  mocr_pkg::mocr_state_t state;
  logic [15:0] measCycles;
  logic [15:0] edgeCount;
  logic [16:0] measKhz;
  logic extLast;
  logic extPrev;
  logic extFiltered;
  logic extRise;
  logic [16:0] oscKhz;
  logic [16:0] monitorKhz;
  logic [16:0] baseKhz;
  logic [16:0] slowKhz;
  logic [16:0] next_cpuKhz;
  logic [16:0] rangeLow;
  logic [16:0] rangeHigh;
  logic outOfRange;
  logic clamped;
  logic [16:0] phase;
  logic [12:0] holdCount;
  logic [12:0] holdTarget;
  logic swWatchdog;
  logic [1:0] timerUseExt;
  logic [7:0] prescReg;
  logic [15:0] cmpA;
  logic [15:0] cmpB;
  logic [15:0] cntA;
  logic [15:0] cntB;
  logic [15:0] capA;
  logic [15:0] capB;
  logic [1:0] cmpHit;
  logic [1:0] capHit;
  logic [1:0] tmrExtLast;
  logic [1:0] tmrExtEdge;
  logic timerRun;
  logic haltReset;
  logic [`MOCR_EV_WIDTH-1:0] status;
  logic [`MOCR_EV_WIDTH-1:0] irqEnable;
  logic [`MOCR_EV_WIDTH-1:0] events;

  ////////////////////////////////////////////////////////////////////////////
  // Options are static; catching them during reset stops mid-run changes from glitching the clocks.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opt <= optionIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // With the supervisor on, a level must be seen twice before it counts, filtering single-cycle glitches.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extPrev <= 1'b0;
      extFiltered <= 1'b0;
      extLast <= 1'b0;
    end else begin
      extPrev <= externalClockInput;
      if (!opt.clockSupervisor || (externalClockInput == extPrev)) begin
        extFiltered <= externalClockInput;
      end
      extLast <= extFiltered;
    end
  end
  assign extRise = extFiltered & ~extLast;

  // Edges over one window give kHz; only inputs below half of sys_clk can be measured.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      measCycles <= 16'h0000;
      edgeCount <= 16'h0000;
      measKhz <= 17'h00000;
    end else if (measCycles == 16'(MEAS_CYCLES - 1)) begin
      measCycles <= 16'h0000;
      edgeCount <= 16'h0000;
      measKhz <= 17'(edgeCount * MEAS_SCALE);
    end else begin
      measCycles <= measCycles + 16'h0001;
      edgeCount <= edgeCount + {15'h0000, extRise};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    unique case (opt.oscSelect)
      mocr_pkg::OSC_16M: monitorKhz = `MOCR_OSC16_KHZ;
      mocr_pkg::OSC_8M: monitorKhz = `MOCR_OSC8_KHZ;
      mocr_pkg::OSC_4M: monitorKhz = `MOCR_OSC4_KHZ;
      mocr_pkg::OSC_2M: monitorKhz = `MOCR_OSC2_KHZ;
      default: monitorKhz = measKhz;
    endcase
  end

  always_comb begin
    unique case (opt.oscillatorRangeSelect)
      mocr_pkg::RANGE_HIGH: begin
        rangeLow = `MOCR_OSC8_KHZ;
        rangeHigh = `MOCR_OSC16_KHZ;
      end
      mocr_pkg::RANGE_MEDIUM: begin
        rangeLow = `MOCR_OSC4_KHZ;
        rangeHigh = `MOCR_OSC8_KHZ;
      end
      mocr_pkg::RANGE_MEDIUM_LOW: begin
        rangeLow = `MOCR_OSC2_KHZ;
        rangeHigh = `MOCR_OSC4_KHZ;
      end
      mocr_pkg::RANGE_LOW: begin
        rangeLow = `MOCR_OSC1_KHZ;
        rangeHigh = `MOCR_OSC2_KHZ;
      end
    endcase
  end

  assign outOfRange = (monitorKhz < rangeLow) || (monitorKhz > rangeHigh);

  // The switch is one-way until reset; hopping back on a marginal clock would chatter.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      backupActive <= 1'b0;
    end else if (opt.clockSupervisor && outOfRange && (measCycles == 16'h0000)) begin
      backupActive <= 1'b1;
    end
  end

  assign oscKhz = backupActive ? `MOCR_BACKUP_KHZ : monitorKhz;

  ////////////////////////////////////////////////////////////////////////////
  // The doubler is applied outside 2..4 MHz too, but flagged there as unguaranteed.
  assign baseKhz = opt.doubler ? 17'(oscKhz << 1) : 17'(oscKhz >> 1);
  assign slowKhz = baseKhz >> opt.slowShift;

  always_comb begin
    next_cpuKhz = slowKhz;
    clamped = 1'b0;
    if (slowKhz > `MOCR_CPU_MAX_KHZ) begin
      next_cpuKhz = `MOCR_CPU_MAX_KHZ;
      clamped = 1'b1;
    end else if (slowKhz < `MOCR_CPU_MIN_KHZ) begin
      next_cpuKhz = `MOCR_CPU_MIN_KHZ;
      clamped = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpuFrequency <= 16'h0000;
    end else begin
      cpuFrequency <= next_cpuKhz[15:0];
    end
  end

  // A phase accumulator spreads the CPU ticks evenly over sys_clk cycles.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase <= 17'h00000;
      cpuTick <= 1'b0;
    end else if ((phase + {1'b0, cpuFrequency}) >= `MOCR_SYS_KHZ) begin
      phase <= phase + {1'b0, cpuFrequency} - `MOCR_SYS_KHZ;
      cpuTick <= 1'b1;
    end else begin
      phase <= phase + {1'b0, cpuFrequency};
      cpuTick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign watchdogActive = opt.watchdogHwEnable | swWatchdog;
  assign haltReset = (state == mocr_pkg::ST_RUN) && haltInstr && watchdogActive
    && opt.watchdogHaltReset;
  assign holdTarget = opt.resetDelayShort ? `MOCR_RST_SHORT : `MOCR_RST_LONG;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= mocr_pkg::ST_RESET_HOLD;
      holdCount <= 13'h0000;
    end else begin
      unique case (state)
        mocr_pkg::ST_RESET_HOLD: begin
          if (cpuTick && (holdCount == holdTarget - 13'h0001)) begin
            state <= mocr_pkg::ST_RUN;
            holdCount <= 13'h0000;
          end else if (cpuTick) begin
            holdCount <= holdCount + 13'h0001;
          end
        end
        mocr_pkg::ST_RUN: begin
          if (haltReset) begin
            state <= mocr_pkg::ST_RESET_HOLD;
          end else if (haltInstr) begin
            state <= mocr_pkg::ST_HALT;
          end
        end
        mocr_pkg::ST_HALT: begin
          if (wakeUp) begin
            state <= mocr_pkg::ST_RESET_HOLD;
          end
        end
      endcase
    end
  end

  assign cpuReset = (state == mocr_pkg::ST_RESET_HOLD);
  assign haltMode = (state == mocr_pkg::ST_HALT);

  ////////////////////////////////////////////////////////////////////////////
  assign externalVoltageDetect = opt.voltageDetectOption & opt.largePackage;
  assign auxiliaryVoltageDetector = externalVoltageDetect;
  assign lowVoltageDetector = externalVoltageDetect & ~haltMode;

  ////////////////////////////////////////////////////////////////////////////
  assign timerRun = ~(opt.freezeOnBreak & breakHalt);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tmrExtLast <= 2'h0;
    end else begin
      tmrExtLast <= timerExternalClock;
    end
  end
  assign tmrExtEdge = timerExternalClock & ~tmrExtLast;

  mocr_timer timerA (
    .sys_clk(sys_clk),
    .rst(rst),
    .cpuTick(cpuTick),
    .run(timerRun),
    .extEdge(tmrExtEdge[0]),
    .useExt(timerUseExt[0]),
    .presc(prescReg[3:0]),
    .compare(cmpA),
    .captureIn(captureIn[0]),
    .counter(cntA),
    .captured(capA),
    .compareHit(cmpHit[0]),
    .captureHit(capHit[0]),
    .pwmOut(pwmOut[0])
  );

  mocr_timer timerB (
    .sys_clk(sys_clk),
    .rst(rst),
    .cpuTick(cpuTick),
    .run(timerRun),
    .extEdge(tmrExtEdge[1]),
    .useExt(timerUseExt[1]),
    .presc(prescReg[7:4]),
    .compare(cmpB),
    .captureIn(captureIn[1]),
    .counter(cntB),
    .captured(capB),
    .compareHit(cmpHit[1]),
    .captureHit(capHit[1]),
    .pwmOut(pwmOut[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      swWatchdog <= 1'b0;
      timerUseExt <= 2'h0;
      prescReg <= 8'h00;
      cmpA <= `MOCR_CMP_RESET;
      cmpB <= `MOCR_CMP_RESET;
      irqEnable <= '0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        `MOCR_REG_CTRL: begin
          swWatchdog <= swWatchdog | bus.wrData[`MOCR_CTRL_WATCHDOG_ENABLE_SOURCE];
          timerUseExt <= {bus.wrData[`MOCR_CTRL_TB_EXT], bus.wrData[`MOCR_CTRL_TA_EXT]};
        end
        `MOCR_REG_PRESC: prescReg <= bus.wrData[7:0];
        `MOCR_REG_TA_CMP: cmpA <= bus.wrData;
        `MOCR_REG_TB_CMP: cmpB <= bus.wrData;
        `MOCR_REG_ENABLE: irqEnable <= bus.wrData[`MOCR_EV_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  assign events = {clamped & ~cpuReset, capHit[1], cmpHit[1], capHit[0], cmpHit[0], haltReset,
    opt.clockSupervisor & outOfRange & ~backupActive & (measCycles == 16'h0000)};

  // A new event outranks a clear written in the same cycle so no event is lost.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= '0;
    end else if (bus.wr && (bus.addr == `MOCR_REG_CLEAR)) begin
      status <= (status & ~bus.wrData[`MOCR_EV_WIDTH-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  assign irq = |(status & irqEnable);

  always_ff @(posedge sys_clk) begin
    if (rst || !bus.rd) begin
      rdData <= 16'h0000;
    end else begin
      unique case (bus.addr)
        `MOCR_REG_STATUS: rdData <= {9'h000, status};
        `MOCR_REG_ENABLE: rdData <= {9'h000, irqEnable};
        `MOCR_REG_CTRL: rdData <= {13'h0000, timerUseExt, swWatchdog};
        `MOCR_REG_FREQ: rdData <= cpuFrequency;
        `MOCR_REG_MEAS: rdData <= measKhz[15:0];
        `MOCR_REG_PRESC: rdData <= {8'h00, prescReg};
        `MOCR_REG_TA_CNT: rdData <= cntA;
        `MOCR_REG_TA_CMP: rdData <= cmpA;
        `MOCR_REG_TA_CAP: rdData <= capA;
        `MOCR_REG_TB_CNT: rdData <= cntB;
        `MOCR_REG_TB_CMP: rdData <= cmpB;
        `MOCR_REG_TB_CAP: rdData <= capB;
        `MOCR_REG_LEVEL: rdData <= {11'h000, haltMode, cpuReset, backupActive, watchdogActive,
          opt.doubler && ((oscKhz < `MOCR_DBL_MIN_KHZ) || (oscKhz > `MOCR_DBL_MAX_KHZ))};
        default: rdData <= 16'h0000;
      endcase
    end
  end
endmodule

/* hw/mocr_cfg.svh */
// Offsets, field positions, reset values and timing counts of the option clock block.
// Assumes one 10 MHz system clock; included by bare name from every source file but the package.
`ifndef MOCR_CFG_SVH
`define MOCR_CFG_SVH
`define MOCR_SYS_KHZ 17'h02710
`define MOCR_OSC16_KHZ 17'h03E80
`define MOCR_OSC8_KHZ 17'h01F40
`define MOCR_OSC4_KHZ 17'h00FA0
`define MOCR_OSC2_KHZ 17'h007D0
`define MOCR_OSC1_KHZ 17'h003E8
`define MOCR_CPU_MIN_KHZ 17'h000FA
`define MOCR_CPU_MAX_KHZ 17'h01F40
`define MOCR_DBL_MIN_KHZ 17'h007D0
`define MOCR_DBL_MAX_KHZ 17'h00FA0
`define MOCR_BACKUP_KHZ 17'h00FA0
`define MOCR_RST_LONG 13'h1000
`define MOCR_RST_SHORT 13'h0100
`define MOCR_MEAS_WINDOW_US 1000
`define MOCR_MEAS_CYCLES ((`MOCR_MEAS_WINDOW_US * 10000) / 1000)
`define MOCR_REG_STATUS 4'h0
`define MOCR_REG_CLEAR 4'h1
`define MOCR_REG_ENABLE 4'h2
`define MOCR_REG_CTRL 4'h3
`define MOCR_REG_FREQ 4'h4
`define MOCR_REG_MEAS 4'h5
`define MOCR_REG_PRESC 4'h6
`define MOCR_REG_TA_CNT 4'h7
`define MOCR_REG_TA_CMP 4'h8
`define MOCR_REG_TA_CAP 4'h9
`define MOCR_REG_TB_CNT 4'hA
`define MOCR_REG_TB_CMP 4'hB
`define MOCR_REG_TB_CAP 4'hC
`define MOCR_REG_LEVEL 4'hD
`define MOCR_EV_SWITCH 0
`define MOCR_EV_WDG_RESET 1
`define MOCR_EV_TA_CMP 2
`define MOCR_EV_TA_CAP 3
`define MOCR_EV_TB_CMP 4
`define MOCR_EV_TB_CAP 5
`define MOCR_EV_CLAMP 6
`define MOCR_EV_WIDTH 7
`define MOCR_CTRL_WATCHDOG_ENABLE_SOURCE 0
`define MOCR_CTRL_TA_EXT 1
`define MOCR_CTRL_TB_EXT 2
`define MOCR_CMP_RESET 16'hFFFF
`endif

/* hw/mocr_pkg.sv */
// Types shared by the option clock block and its bench.
// Assumes the constants of mocr_cfg.svh for every figure.
package mocr_pkg;
  typedef enum logic [2:0] {OSC_16M, OSC_8M, OSC_4M, OSC_2M, OSC_EXT} mocr_osc_t;
  typedef enum logic [1:0] {RANGE_HIGH, RANGE_MEDIUM, RANGE_MEDIUM_LOW, RANGE_LOW} mocr_range_t;
  typedef enum {ST_RESET_HOLD, ST_RUN, ST_HALT} mocr_state_t;
  typedef struct packed {
    mocr_osc_t oscSelect;
    logic doubler;
    logic [2:0] slowShift;
    logic freezeOnBreak;
    logic clockSupervisor;
    mocr_range_t oscillatorRangeSelect;
    logic resetDelayShort;
    logic watchdogHaltReset;
    logic watchdogHwEnable;
    logic voltageDetectOption;
    logic largePackage;
  } mocr_opt_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wrData;
    logic wr;
    logic rd;
  } mocr_bus_t;
endpackage

/* test/mocr_clock_reset_props.sv */
// Checker for the option clock block, watching its top ports only.
// Assumes one sys_clk domain with synchronous active-high rst.
`timescale 1ns/10ps
`include "mocr_cfg.svh"

module mocr_clock_reset_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire mocr_pkg::mocr_opt_t optionIn,
  input wire mocr_pkg::mocr_bus_t bus,
  input wire logic [15:0] rdData,
  input wire logic haltInstr,
  input wire logic wakeUp,
  input wire logic [15:0] cpuFrequency,
  input wire logic cpuReset,
  input wire logic haltMode,
  input wire logic backupActive,
  input wire logic watchdogActive,
  input wire logic externalVoltageDetect,
  input wire logic lowVoltageDetector,
  input wire logic auxiliaryVoltageDetector
);
  mocr_pkg::mocr_opt_t optHeld;

  ////////////////////////////////////////////////////////////////////////////////
  // Options are copied only under reset, so a bench that moves them later cannot mislead the checks.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      optHeld <= optionIn;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  freq_range_a: assert property (cpuFrequency != 16'h0000 |->
    cpuFrequency >= `MOCR_CPU_MIN_KHZ && cpuFrequency <= `MOCR_CPU_MAX_KHZ)
    else $error("CPU frequency out of band.");
  rd_idle_a: assert property (!$past(bus.rd) |-> rdData == 16'h0000)
    else $error("Read data outside its cycle.");
  wdg_reset_a: assert property (haltInstr && !haltMode && !cpuReset && watchdogActive &&
    optHeld.watchdogHaltReset |=> cpuReset [*2])
    else $error("Halt with watchdog did not reset.");
  halt_noreset_a: assert property (haltInstr && !haltMode && !cpuReset &&
    !(watchdogActive && optHeld.watchdogHaltReset) |=> haltMode && !cpuReset)
    else $error("Halt without reset option misbehaved.");
  wake_hold_a: assert property (haltMode && wakeUp |=> cpuReset && !haltMode)
    else $error("Halt exit did not start the hold.");
  wdg_hw_a: assert property (optHeld.watchdogHwEnable |-> watchdogActive)
    else $error("Hardware watchdog not active.");
  backup_sticky_a: assert property (backupActive |=> $stable(backupActive))
    else $error("Backup switch dropped.");
  backup_off_a: assert property (!optHeld.clockSupervisor |-> !backupActive)
    else $error("Backup without supervisor.");
  vd_opt_a: assert property (externalVoltageDetect ==
    (optHeld.voltageDetectOption && optHeld.largePackage) && auxiliaryVoltageDetector == externalVoltageDetect)
    else $error("Voltage detect option not followed.");
  lvd_halt_a: assert property (haltMode |-> !lowVoltageDetector)
    else $error("Low voltage detector on in halt.");
  lvd_run_a: assert property (!haltMode |-> lowVoltageDetector == externalVoltageDetect)
    else $error("Low voltage detector off in run.");
endmodule

bind mocr_clock_reset mocr_clock_reset_props i_mocr_clock_reset_props (.sys_clk(sys_clk), .rst(rst),
  .optionIn(optionIn), .bus(bus), .rdData(rdData), .haltInstr(haltInstr), .wakeUp(wakeUp),
  .cpuFrequency(cpuFrequency), .cpuReset(cpuReset), .haltMode(haltMode), .backupActive(backupActive),
  .watchdogActive(watchdogActive), .externalVoltageDetect(externalVoltageDetect),
  .lowVoltageDetector(lowVoltageDetector), .auxiliaryVoltageDetector(auxiliaryVoltageDetector));

/* test/tb.sv */
// Self-checking bench for the option clock block.
// Assumes the design under hw/ and the constants of mocr_cfg.svh.
`timescale 1ns/10ps
`include "mocr_cfg.svh"

module tb;
  typedef struct {mocr_pkg::mocr_osc_t osc; logic dbl; logic [2:0] sh; logic short;
    logic [15:0] freq; logic dblBad; logic clamp;} mocr_row_t;
  mocr_row_t rows [8] = '{
    '{mocr_pkg::OSC_16M, 1'b0, 3'h0, 1'b0, 16'h1F40, 1'b0, 1'b0},
    '{mocr_pkg::OSC_8M, 1'b0, 3'h0, 1'b1, 16'h0FA0, 1'b0, 1'b0},
    '{mocr_pkg::OSC_4M, 1'b0, 3'h1, 1'b1, 16'h03E8, 1'b0, 1'b0},
    '{mocr_pkg::OSC_2M, 1'b0, 3'h2, 1'b1, 16'h00FA, 1'b0, 1'b0},
    '{mocr_pkg::OSC_2M, 1'b0, 3'h3, 1'b1, 16'h00FA, 1'b0, 1'b1},
    '{mocr_pkg::OSC_16M, 1'b1, 3'h0, 1'b1, 16'h1F40, 1'b1, 1'b1},
    '{mocr_pkg::OSC_4M, 1'b1, 3'h0, 1'b1, 16'h1F40, 1'b0, 1'b0},
    '{mocr_pkg::OSC_2M, 1'b1, 3'h1, 1'b1, 16'h07D0, 1'b0, 1'b0}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  mocr_pkg::mocr_opt_t opt = '0;
  mocr_pkg::mocr_opt_t o;
  mocr_pkg::mocr_bus_t bus = '0;
  logic external_clock_input = 1'b0;
  logic extRun = 1'b0;
  logic extDiv = 1'b0;
  logic [1:0] tExt = 2'h0;
  logic [1:0] capIn = 2'h0;
  logic breakHalt = 1'b0;
  logic haltInstr = 1'b0;
  logic wakeUp = 1'b0;
  logic [15:0] rdData, cpuFrequency, a, b, c, d;
  logic cpuTick, cpuReset, haltMode, backupActive, watchdogActive, external_voltage_detect, low_voltage_detector, auxiliary_voltage_detector, irq;
  logic [1:0] pwmOut;
  int n_errors = 0;
  int n_tests = 0;
  int holdTicks = 0;

  always #50 sys_clk = ~sys_clk;

  // A small window keeps each supervisor decision near a thousand cycles; readings scale by ten.
  mocr_clock_reset #(.MEAS_CYCLES(1000)) i_mocr_clock_reset (.sys_clk(sys_clk), .rst(rst), .optionIn(opt),
    .bus(bus), .rdData(rdData), .externalClockInput(external_clock_input), .timerExternalClock(tExt), .captureIn(capIn),
    .breakHalt(breakHalt), .haltInstr(haltInstr), .wakeUp(wakeUp), .cpuFrequency(cpuFrequency),
    .cpuTick(cpuTick), .cpuReset(cpuReset), .haltMode(haltMode), .backupActive(backupActive),
    .watchdogActive(watchdogActive), .externalVoltageDetect(external_voltage_detect), .lowVoltageDetector(low_voltage_detector),
    .auxiliaryVoltageDetector(auxiliary_voltage_detector), .pwmOut(pwmOut), .irq(irq));

  // Two cycles per level so the clock filter passes every edge: 2500 kHz.
  always @(posedge sys_clk) begin
    extDiv <= ~extDiv;
    if (extRun && extDiv) begin
      external_clock_input <= ~external_clock_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] v);
    @(posedge sys_clk);
    bus <= {ad, v, 2'b10};
    @(posedge sys_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [3:0] ad, output logic [15:0] v);
    @(posedge sys_clk);
    bus <= {ad, 16'h0000, 2'b01};
    @(posedge sys_clk);
    bus <= '0;
    @(negedge sys_clk);
    v = rdData;
  endtask

  task automatic holdWait();
    holdTicks = 0;
    for (int i = 0; i < 20000; i++) begin
      if (cpuReset !== 1'b1) break;
      if (cpuTick === 1'b1) holdTicks++;
      @(negedge sys_clk);
    end
  endtask

  task automatic start(input mocr_pkg::mocr_opt_t v);
    @(posedge sys_clk);
    opt <= v;
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    holdWait();
  endtask

  task automatic pulse(input int which);
    @(posedge sys_clk);
    if (which == 0) haltInstr <= 1'b1;
    else wakeUp <= 1'b1;
    @(posedge sys_clk);
    haltInstr <= 1'b0;
    wakeUp <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic extPulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      tExt[0] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      tExt[0] <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
  endtask

  function automatic mocr_pkg::mocr_opt_t mkOpt(input mocr_pkg::mocr_osc_t osc, input logic dbl,
    input logic [2:0] sh, input logic short);
    mocr_pkg::mocr_opt_t v;
    v = '0;
    v.oscSelect = osc;
    v.doubler = dbl;
    v.slowShift = sh;
    v.freezeOnBreak = 1'b1;
    v.clockSupervisor = 1'b1;
    v.oscillatorRangeSelect = mocr_pkg::mocr_range_t'(2'(osc));
    v.resetDelayShort = short;
    v.voltageDetectOption = 1'b1;
    v.largePackage = 1'b1;
    return v;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    $display("mismatch watchdog expected done seen timeout");
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (rows[i]) begin
      start(mkOpt(rows[i].osc, rows[i].dbl, rows[i].sh, rows[i].short));
      check("holdTicks", 16'(holdTicks), rows[i].short ? `MOCR_RST_SHORT : `MOCR_RST_LONG);
      repeat (2200) @(negedge sys_clk);
      check("cpuFrequency", cpuFrequency, rows[i].freq);
      check("backupActive", 16'(backupActive), 16'h0000);
      rd(`MOCR_REG_FREQ, d);
      check("freqReg", d, rows[i].freq);
      rd(`MOCR_REG_LEVEL, d);
      check("doublerBand", 16'(d[0]), 16'(rows[i].dblBad));
      rd(`MOCR_REG_STATUS, d);
      check("clampFlag", 16'(d[`MOCR_EV_CLAMP]), 16'(rows[i].clamp));
      $display("row %0d done", i);
    end
    rd(4'hE, d);
    check("unmapped", d, 16'h0000);
    wr(`MOCR_REG_FREQ, 16'h1234);
    rd(`MOCR_REG_FREQ, d);
    check("freqReadOnly", d, 16'h07D0);
    @(posedge sys_clk);
    opt <= mkOpt(mocr_pkg::OSC_16M, 1'b0, 3'h0, 1'b0);
    repeat (20) @(negedge sys_clk);
    check("optionsHeld", cpuFrequency, 16'h07D0);
    $display("bus test done");
    wr(`MOCR_REG_PRESC, 16'h0000);
    @(posedge sys_clk);
    breakHalt <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`MOCR_REG_TA_CNT, a);
    repeat (50) @(posedge sys_clk);
    rd(`MOCR_REG_TA_CNT, b);
    check("frozenCount", b, a);
    wr(`MOCR_REG_CTRL, 16'h0002);
    extPulses(10);
    rd(`MOCR_REG_TA_CNT, c);
    check("extCount", c, b + 16'h000A);
    @(posedge sys_clk);
    capIn <= 2'h1;
    repeat (3) @(posedge sys_clk);
    capIn <= 2'h0;
    rd(`MOCR_REG_TA_CAP, d);
    check("captured", d, c);
    check("pwmBelow", 16'(pwmOut), 16'h0003);
    wr(`MOCR_REG_TA_CMP, c + 16'h0002);
    extPulses(3);
    check("pwmReached", 16'(pwmOut[0]), 16'h0000);
    rd(`MOCR_REG_STATUS, d);
    check("cmpCapFlags", 16'(d[3:2]), 16'h0003);
    wr(`MOCR_REG_CTRL, 16'h0000);
    @(posedge sys_clk);
    breakHalt <= 1'b0;
    repeat (50) @(posedge sys_clk);
    rd(`MOCR_REG_TA_CNT, d);
    check("runningCount", 16'(d > c + 16'h0003), 16'h0001);
    $display("timer test done");
    o = mkOpt(mocr_pkg::OSC_4M, 1'b0, 3'h0, 1'b1);
    o.freezeOnBreak = 1'b0;
    o.clockSupervisor = 1'b0;
    o.watchdogHwEnable = 1'b1;
    o.watchdogHaltReset = 1'b1;
    start(o);
    check("hwWatchdog", 16'(watchdogActive), 16'h0001);
    check("lvdRun", 16'({low_voltage_detector, external_voltage_detect, auxiliary_voltage_detector}), 16'h0007);
    @(posedge sys_clk);
    breakHalt <= 1'b1;
    rd(`MOCR_REG_TA_CNT, a);
    repeat (50) @(posedge sys_clk);
    rd(`MOCR_REG_TA_CNT, b);
    check("runOnBreak", 16'(b > a), 16'h0001);
    pulse(0);
    check("haltReset", 16'({cpuReset, haltMode}), 16'h0002);
    holdWait();
    check("haltHold", 16'(holdTicks), `MOCR_RST_SHORT);
    rd(`MOCR_REG_STATUS, d);
    check("wdgFlag", 16'({d[`MOCR_EV_WDG_RESET], irq}), 16'h0002);
    wr(`MOCR_REG_ENABLE, 16'h0002);
    @(negedge sys_clk);
    check("irqOn", 16'(irq), 16'h0001);
    wr(`MOCR_REG_CLEAR, 16'h0002);
    @(negedge sys_clk);
    check("irqOff", 16'(irq), 16'h0000);
    $display("watchdog reset test done");
    o.watchdogHwEnable = 1'b0;
    o.watchdogHaltReset = 1'b0;
    start(o);
    check("swWatchdogOff", 16'(watchdogActive), 16'h0000);
    wr(`MOCR_REG_CTRL, 16'h0001);
    @(negedge sys_clk);
    check("swWatchdogOn", 16'(watchdogActive), 16'h0001);
    pulse(0);
    check("haltNoReset", 16'({haltMode, cpuReset, low_voltage_detector, auxiliary_voltage_detector}), 16'h0009);
    pulse(1);
    holdWait();
    check("wakeHold", 16'(holdTicks), `MOCR_RST_SHORT);
    check("awake", 16'(haltMode), 16'h0000);
    $display("halt test done");
    o = mkOpt(mocr_pkg::OSC_EXT, 1'b0, 3'h0, 1'b1);
    o.largePackage = 1'b0;
    @(posedge sys_clk);
    extRun <= 1'b1;
    start(o);
    repeat (2500) @(negedge sys_clk);
    rd(`MOCR_REG_MEAS, d);
    check("measBand", 16'(d >= 16'h09BA && d <= 16'h09CE), 16'h0001);
    check("backupOn", 16'(backupActive), 16'h0001);
    check("vdSmall", 16'({external_voltage_detect, auxiliary_voltage_detector, low_voltage_detector}), 16'h0000);
    rd(`MOCR_REG_STATUS, d);
    check("switchFlag", 16'(d[`MOCR_EV_SWITCH]), 16'h0001);
    $display("supervisor test done");
    finish_test();
  end
endmodule
